// *** bench/qfp_flash_model.sv ***
// behavioural flash that answers factory program sequences on its pins
// assumes write data is taken at the rising write strobe; fail injects a program error
`timescale 1ns/1ps
module qfp_flash_model #(parameter int PROG_NS = 400, parameter int BLK_LSB = 15) (
  // pins
  input wire logic [20:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic        fl_ce_n,
  input wire logic        fl_we_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_rst_n,
  input wire logic        fail,
  output logic     [15:0] dq
);
  logic [2:0] mode, cnt, nw;
  logic prog = 0, err, srd;
  logic [5:0] blk;
  logic [15:0] pg [4];
  logic [20:0] pa0;
  logic [15:0] last = 0;
  int npg = 0;
  wire [7:0] sr = {~(prog | mode == 1 | mode == 3), 2'b0, err, 3'b0, prog};
  wire rd = !fl_ce_n && !fl_oe_n;
  // once a command has run, plain reads keep showing status until a flash reset
  wire [15:0] val = (mode != 0 || prog || srd) ? {8'h00, sr} : fl_addr[15:0];
  // a released bus shows the inverse so stale data never passes
  always @(*) if (rd) last = val;
  assign dq = rd ? val : ~last;
  always @(posedge prog) prog <= #PROG_NS 1'b0;
  always @(posedge fl_we_n or negedge fl_rst_n)
    if (!fl_rst_n) begin
      mode = 0; cnt = 0; prog = 0; err = 0; srd = 0;
    end else if (mode == 0) begin
      blk = fl_addr[20:BLK_LSB]; cnt = 0;
      nw = fl_dq_o == 16'h0035 ? 3'h2 : 3'h4;
      case (fl_dq_o)
        16'h0075: mode = 1;
        16'h0035, 16'h0056: mode = 2;
        16'h0030: mode = 4;
        default: ;
      endcase
      srd = srd | (mode != 0);
    end else if (mode == 4) mode = fl_dq_o == 16'h00d0 ? 3'h3 : 3'h0;
    else if (fl_dq_o == 16'hffff && fl_addr[20:BLK_LSB] != blk && cnt == 0 && mode != 2)
      mode = 0;
    else begin
      if (cnt == 0) pa0 = fl_addr;
      pg[cnt[1:0]] = fl_dq_o;
      cnt = mode == 3 ? 3'h0 : cnt + 3'h1;
      if (mode == 3 || cnt == nw) begin
        prog = 1; err = err | fail; cnt = 0; npg++;
        if (mode == 2) mode = 0;
      end
    end
endmodule // qfp_flash_model

// *** bench/qfp_host_sva.sv ***
// pin and register bus checks for the factory program host controller
// assumes it is bound to qfp_host and sees only its ports
`timescale 1ns/1ps
module qfp_host_sva (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   arst_n,
  // register bus
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  // flash pins
  input wire logic [qfp_pkg::AW-1:0] fl_addr,
  input wire logic [qfp_pkg::DW-1:0] fl_dq_o,
  input wire logic                   fl_dq_oe,
  input wire logic                   fl_ce_n,
  input wire logic                   fl_we_n,
  input wire logic                   fl_oe_n,
  input wire logic                   fl_rst_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // prdata is only loaded by a read setup, so a write leaves the last read value standing
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h1c |->
                                 pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_STROBE_EXCL: assert property (!(!fl_we_n && !fl_oe_n))
    else $error("read and write strobes together");
  AST_WE_IN_CE: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe)
    else $error("write strobe outside a driven cycle");
  AST_RD_FREE: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n)
    else $error("data driven during read");
  AST_WE_SETUP: assert property ($fell(fl_we_n) |-> $past(fl_ce_n, 3) == 1'b0)
    else $error("write strobe without setup time");
  AST_WE_WIDTH: assert property ($fell(fl_we_n) |-> !fl_we_n [*8])
    else $error("write pulse too short");
  AST_WR_HOLD: assert property (!fl_we_n && !$past(fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_o))
    else $error("address or data moved in write pulse");
  AST_DQ_REC: assert property ($rose(fl_we_n) |-> fl_dq_oe [*8])
    else $error("data released before recovery");
  AST_RST_QUIET: assert property (!fl_rst_n |-> fl_ce_n && fl_we_n)
    else $error("bus cycle while flash held in reset");
endmodule // qfp_host_sva
bind qfp_host qfp_host_sva qfp_host_sva_inst (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_rst_n);

// *** bench/tb_qfp_host.sv ***
// testbench for the factory program host controller over apb
// assumes the flash model stands on the pins with its default timing
`timescale 1ns/1ps
module tb_qfp_host;
  logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, fail = 0, perr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic pready, pslverr, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_rst_n;
  logic [20:0] fl_addr;
  logic [15:0] fl_dq_i, fl_dq_o;
  int fail_count = 0, n_compared = 0;
  qfp_host qfp_host_inst (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_we_n, .fl_oe_n,
    .fl_rst_n);
  qfp_flash_model m (.fl_addr, .fl_dq_o, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_rst_n, .fail,
    .dq(fl_dq_i));
  always #2 clock = ~clock;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata; perr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] mk);
    n_compared++;
    if ((g & mk) !== (e & mk)) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  // go, then poll status until busy drops; the watchdog bounds a hang
  task automatic run(input logic [7:0] ctl);
    apb(1, 8'h00, {24'h0, ctl});
    do apb(0, 8'h1c, 0); while (rd[0] !== 1'b0);
  endtask
  task automatic page(input logic [15:0] b);
    for (int i = 0; i < 4; i++) apb(1, 8'h0c + 8'(4 * i), {16'h0, b + 16'(i)});
  endtask
  task automatic finish_test;
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1;
    apb(0, 8'h1c, 0); chk(rd, 0, '1);
    apb(0, 8'h24, 0); chk({rd[30:0], perr}, 1, '1);
    apb(1, 8'h04, 32'h8010); apb(1, 8'h08, 32'h100000);
    page(16'ha0); run(8'h0b);
    chk(rd, 32'h22, 32'hfffffffb);
    for (int i = 0; i < 4; i++) chk(m.pg[i], 16'ha0 + i, '1);
    chk(m.pa0, 32'h8010, '1);
    page(16'hb0); run(8'h0c);
    chk(m.npg, 2, '1);
    chk(m.pg[3], 32'hb3, '1);
    run(8'h09); chk(rd, 32'h4, 32'h4);
    chk(m.npg, 2, '1);
    run(8'h1f); chk(rd, 32'h8002, 32'hfffffffb);
    chk(m.mode, 0, '1);
    for (int i = 0; i < 2; i++) begin
      page(16'hc0); run(8'h09 + 8'(i));
      chk(m.npg, 3 + i, '1);
      chk(m.pg[1], 32'hc1, '1);
      chk(rd, 32'h8002, 32'hfffffffb);
    end
    run(8'h0d); chk(rd, 32'h40, 32'h40);
    run(8'h0e); chk(m.pg[0], 32'hc0, '1);
    run(8'h1f); chk(rd, 32'h8002, 32'hfffffffb);
    fail <= 1;
    page(16'hd0); run(8'h0b); run(8'h1f);
    chk(rd, 32'h9012, 32'hfffffffb);
    fail <= 0;
    run(8'h0b); apb(1, 8'h00, 32'h20); apb(1, 8'h00, 0);
    chk(m.mode, 0, '1);
    chk(m.err, 0, '1);
    apb(0, 8'h1c, 0); chk(rd, 0, 32'h21);
    finish_test;
  end
endmodule // tb_qfp_host

// *** src/qfp_bus_cycle.sv ***
// one asynchronous flash bus write or read cycle per request
// assumes req is held until ack and rdata is already synchronised
`timescale 1ns/1ps
module qfp_bus_cycle (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  // request side
  input  wire logic                   req,
  input  wire logic                   we,
  input  wire logic [qfp_pkg::AW-1:0] addr,
  input  wire logic [qfp_pkg::DW-1:0] wdata,
  input  wire logic [qfp_pkg::DW-1:0] rdata,
  output logic                        ack,
  output logic                        busy,
  output logic      [qfp_pkg::DW-1:0] rd_q,
  // flash pins
  output logic      [qfp_pkg::AW-1:0] fl_addr,
  output logic      [qfp_pkg::DW-1:0] fl_dq_o,
  output logic                        fl_dq_oe,
  output logic                        fl_ce_n,
  output logic                        fl_we_n,
  output logic                        fl_oe_n
);
  qfp_pkg::qfp_bus_t        ph_q;
  logic [qfp_pkg::CW-1:0]   cnt_q;
  logic                     we_q;

  assign busy = (ph_q != qfp_pkg::B_IDLE);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ph_q     <= qfp_pkg::B_IDLE;
      cnt_q    <= '0;
      we_q     <= 1'b0;
      ack      <= 1'b0;
      rd_q     <= '0;
      fl_addr  <= '0;
      fl_dq_o  <= '0;
      fl_dq_oe <= 1'b0;
      fl_ce_n  <= 1'b1;
      fl_we_n  <= 1'b1;
      fl_oe_n  <= 1'b1;
    end else begin
      ack <= 1'b0;
      if (cnt_q != '0) cnt_q <= cnt_q - qfp_pkg::CNT_ONE;
      unique case (ph_q)
        qfp_pkg::B_IDLE: begin
          // ack still high means the requester has not yet dropped req
          if (req && !ack) begin
            fl_addr  <= addr;
            fl_dq_o  <= wdata;
            fl_dq_oe <= we;
            we_q     <= we;
            fl_ce_n  <= 1'b0;
            cnt_q    <= qfp_pkg::SETUP_CYC - qfp_pkg::CNT_ONE;
            ph_q     <= qfp_pkg::B_SETUP;
          end
        end
        qfp_pkg::B_SETUP: begin
          if (cnt_q == '0) begin
            fl_we_n <= ~we_q;
            fl_oe_n <= we_q;
            cnt_q   <= (we_q ? qfp_pkg::WR_CYC : qfp_pkg::RD_CYC) - qfp_pkg::CNT_ONE;
            ph_q    <= qfp_pkg::B_PULSE;
          end
        end
        qfp_pkg::B_PULSE: begin
          if (cnt_q == '0) begin
            if (!we_q) rd_q <= rdata;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
            cnt_q   <= qfp_pkg::REC_CYC - qfp_pkg::CNT_ONE;
            ph_q    <= qfp_pkg::B_REC;
          end
        end
        qfp_pkg::B_REC: begin
          // data held past the strobe for hold time, then released
          if (cnt_q == '0) begin
            fl_dq_oe <= 1'b0;
            ack      <= 1'b1;
            ph_q     <= qfp_pkg::B_IDLE;
          end
        end
      endcase
    end
  end
endmodule // qfp_bus_cycle

// *** src/qfp_host.sv ***
// host controller that runs the flash factory program sequences over its bus pins
// assumes software drives it over apb; the flash answers status on plain reads
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
// Behaviour
// - quad pages use four words, low bits only
// - quad session opens with one 75h write
// - never send read-status code inside session
// - four page writes go out without break; the code puts a status read after the first word of the first page after 75h
// - first load only: check ready bit low
// - next page is one more load
// - check all status bits after termination
// - double word: 35h then pair, A0
// - quad word: 56h then four words
// - setup code written at bank address
// - d0h confirm, streams end with ffffh
// - status read between stream data writes
module qfp_host (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // flash pins
  output logic      [qfp_pkg::AW-1:0] fl_addr,
  input  wire logic [qfp_pkg::DW-1:0] fl_dq_i,
  output logic      [qfp_pkg::DW-1:0] fl_dq_o,
  output logic                        fl_dq_oe,
  output logic                        fl_ce_n,
  output logic                        fl_we_n,
  output logic                        fl_oe_n,
  output logic                        fl_rst_n
);
  qfp_pkg::qfp_state_t           state_q;
  qfp_pkg::qfp_op_t              op_q;
  logic                          wait_q;
  logic                          flrst_q;
  logic [qfp_pkg::AW-1:0]        start_q;
  logic [qfp_pkg::AW-1:0]        exit_q;
  logic [qfp_pkg::DW-1:0]        word_q [qfp_pkg::NWORDS];
  logic [1:0]                    idx_q;
  logic                          first_q;
  logic                          qefp_q;
  logic                          efp_q;
  logic                          done_q;
  logic                          refused_q;
  logic                          acc_err_q;
  logic                          dev_err_q;
  logic [7:0]                    sr_q;

  logic                          bus_req;
  logic                          bus_we;
  logic [qfp_pkg::AW-1:0]        bus_addr;
  logic [qfp_pkg::DW-1:0]        bus_wdata;
  logic                          bus_ack;
  logic                          bus_busy;
  logic [qfp_pkg::DW-1:0]        bus_rd;
  logic [qfp_pkg::DW-1:0]        dq_sync;

  logic                          wr_en;
  logic                          rd_setup;
  logic                          mapped;
  logic                          go;
  logic                          allowed;
  logic [1:0]                    last_idx;
  logic [qfp_pkg::AW-1:0]        word_addr;
  logic                          poll_done;
  logic [31:0]                   status_word;
  logic [31:0]                   rd_mux;

  // ---------------------------------------------------------------- apb slave
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  always_comb begin
    mapped = (paddr == qfp_pkg::REG_CTRL) || (paddr == qfp_pkg::REG_START) ||
             (paddr == qfp_pkg::REG_EXIT) || (paddr == qfp_pkg::REG_STATUS) ||
             (paddr[1:0] == 2'b00 && paddr[7:2] >= qfp_pkg::WORD0_IDX &&
              paddr[7:2] < qfp_pkg::WORD0_IDX + 6'(qfp_pkg::NWORDS));
  end
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    status_word = '0;
    status_word[qfp_pkg::ST_BUSY]    = (state_q != qfp_pkg::S_IDLE);
    status_word[qfp_pkg::ST_DONE]    = done_q;
    status_word[qfp_pkg::ST_REFUSED] = refused_q;
    status_word[qfp_pkg::ST_ACC_ERR] = acc_err_q;
    status_word[qfp_pkg::ST_DEV_ERR] = dev_err_q;
    status_word[qfp_pkg::ST_QEFP]    = qefp_q;
    status_word[qfp_pkg::ST_EFP]     = efp_q;
    status_word[qfp_pkg::ST_SR_LSB +: 8] = sr_q;
  end

  always_comb begin
    rd_mux = '0;
    if (paddr == qfp_pkg::REG_CTRL) begin
      rd_mux[qfp_pkg::CTRL_OP_LSB +: 3] = op_q;
      rd_mux[qfp_pkg::CTRL_WAIT]        = wait_q;
      rd_mux[qfp_pkg::CTRL_FLRST]       = flrst_q;
    end else if (paddr == qfp_pkg::REG_START) begin
      rd_mux[qfp_pkg::AW-1:0] = start_q;
    end else if (paddr == qfp_pkg::REG_EXIT) begin
      rd_mux[qfp_pkg::AW-1:0] = exit_q;
    end else if (paddr == qfp_pkg::REG_STATUS) begin
      rd_mux = status_word;
    end else if (mapped) begin
      rd_mux[qfp_pkg::DW-1:0] = word_q[2'(paddr[7:2] - qfp_pkg::WORD0_IDX)];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) prdata <= '0;
    else if (rd_setup) prdata <= rd_mux;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= '0;
      exit_q  <= '0;
    end else if (wr_en) begin
      if (paddr == qfp_pkg::REG_START) start_q <= pwdata[qfp_pkg::AW-1:0];
      if (paddr == qfp_pkg::REG_EXIT)  exit_q  <= pwdata[qfp_pkg::AW-1:0];
    end
  end

  genvar w;
  generate
    for (w = 0; w < qfp_pkg::NWORDS; w++) begin : g_word
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) word_q[w] <= '0;
        else if (wr_en && paddr == qfp_pkg::REG_WORD0 + 8'(4 * w))
          word_q[w] <= pwdata[qfp_pkg::DW-1:0];
      end
    end
  endgenerate

  // ---------------------------------------------------------------- command start
  assign go = wr_en && (paddr == qfp_pkg::REG_CTRL) && pwdata[qfp_pkg::CTRL_GO];

  // inside a session only its own loads, the exit and plain status reads go out
  always_comb begin
    if (qefp_q)
      allowed = (qfp_pkg::qfp_op_t'(pwdata[2:0]) inside
                 {qfp_pkg::OP_QEFP_PAGE, qfp_pkg::OP_EXIT, qfp_pkg::OP_READ});
    else if (efp_q)
      allowed = (qfp_pkg::qfp_op_t'(pwdata[2:0]) inside
                 {qfp_pkg::OP_EFP_WORD, qfp_pkg::OP_EXIT, qfp_pkg::OP_READ});
    else
      allowed = !(qfp_pkg::qfp_op_t'(pwdata[2:0]) inside
                  {qfp_pkg::OP_QEFP_PAGE, qfp_pkg::OP_EFP_WORD, qfp_pkg::OP_EXIT});
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) flrst_q <= 1'b0;
    else if (wr_en && paddr == qfp_pkg::REG_CTRL) flrst_q <= pwdata[qfp_pkg::CTRL_FLRST];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) fl_rst_n <= 1'b0;
    else         fl_rst_n <= ~flrst_q;
  end

  // ---------------------------------------------------------------- bus request
  always_comb begin
    unique case (op_q)
      qfp_pkg::OP_DWP:      last_idx = 2'b01;
      qfp_pkg::OP_EFP_WORD: last_idx = 2'b00;
      default:              last_idx = 2'b11;
    endcase
  end

  always_comb begin
    word_addr = start_q;
    if (idx_q != 2'b00 && op_q == qfp_pkg::OP_DWP)
      word_addr = {start_q[qfp_pkg::AW-1:1], idx_q[0]};
    else if (idx_q != 2'b00)
      word_addr = {start_q[qfp_pkg::AW-1:2], idx_q};
  end

  always_comb begin
    bus_req   = 1'b0;
    bus_we    = 1'b1;
    bus_addr  = start_q;
    bus_wdata = '0;
    unique case (state_q)
      qfp_pkg::S_SETUP: begin
        bus_req = 1'b1;
        unique case (op_q)
          qfp_pkg::OP_DWP:       bus_wdata = qfp_pkg::CODE_DWP;
          qfp_pkg::OP_QWP:       bus_wdata = qfp_pkg::CODE_QWP;
          qfp_pkg::OP_EFP_START: bus_wdata = qfp_pkg::CODE_EFP;
          default:               bus_wdata = qfp_pkg::CODE_QEFP;
        endcase
      end
      qfp_pkg::S_CONFIRM: begin
        bus_req   = 1'b1;
        bus_wdata = qfp_pkg::CODE_CONFIRM;
      end
      qfp_pkg::S_WORD: begin
        bus_req   = 1'b1;
        bus_addr  = word_addr;
        bus_wdata = word_q[idx_q];
      end
      // plain reads only: the device already answers with status
      qfp_pkg::S_CHECK, qfp_pkg::S_POLL: begin
        bus_req = 1'b1;
        bus_we  = 1'b0;
      end
      qfp_pkg::S_EXIT: begin
        bus_req   = 1'b1;
        bus_addr  = exit_q;
        bus_wdata = qfp_pkg::EXIT_DATA;
      end
      default: bus_req = 1'b0;
    endcase
  end

  // page and word loads wait on bank-write low, plain reads end at once, everything else on ready high
  always_comb begin
    unique case (op_q)
      qfp_pkg::OP_READ: poll_done = 1'b1;
      qfp_pkg::OP_QEFP_START, qfp_pkg::OP_QEFP_PAGE, qfp_pkg::OP_EFP_WORD:
        poll_done = !bus_rd[qfp_pkg::SR_BANKW];
      default: poll_done = bus_rd[qfp_pkg::SR_READY];
    endcase
  end

  // ---------------------------------------------------------------- sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= qfp_pkg::S_IDLE;
      op_q    <= qfp_pkg::OP_READ;
      wait_q  <= 1'b0;
      idx_q   <= 2'b00;
      first_q <= 1'b0;
    end else if (flrst_q) begin
      state_q <= qfp_pkg::S_IDLE;
      first_q <= 1'b0;
    end else begin
      unique case (state_q)
        qfp_pkg::S_IDLE: begin
          if (go && allowed && !bus_busy) begin
            op_q    <= qfp_pkg::qfp_op_t'(pwdata[qfp_pkg::CTRL_OP_LSB +: 3]);
            wait_q  <= pwdata[qfp_pkg::CTRL_WAIT];
            idx_q   <= 2'b00;
            first_q <= (pwdata[2:0] == qfp_pkg::OP_QEFP_START);
            unique case (qfp_pkg::qfp_op_t'(pwdata[2:0]))
              qfp_pkg::OP_READ:      state_q <= qfp_pkg::S_POLL;
              qfp_pkg::OP_QEFP_PAGE,
              qfp_pkg::OP_EFP_WORD:  state_q <= qfp_pkg::S_WORD;
              qfp_pkg::OP_EXIT:      state_q <= qfp_pkg::S_EXIT;
              default:               state_q <= qfp_pkg::S_SETUP;
            endcase
          end
        end
        qfp_pkg::S_SETUP: if (bus_ack) begin
          state_q <= (op_q == qfp_pkg::OP_EFP_START) ? qfp_pkg::S_CONFIRM : qfp_pkg::S_WORD;
        end
        qfp_pkg::S_CONFIRM: if (bus_ack) state_q <= qfp_pkg::S_FINISH;
        qfp_pkg::S_WORD: if (bus_ack) begin
          if (first_q) state_q <= qfp_pkg::S_CHECK;
          else if (idx_q == last_idx) state_q <= qfp_pkg::S_POLL;
          else idx_q <= idx_q + 2'b01;
        end
        qfp_pkg::S_CHECK: if (bus_ack) begin
          first_q <= 1'b0;
          idx_q   <= idx_q + 2'b01;
          state_q <= qfp_pkg::S_WORD;
        end
        qfp_pkg::S_POLL: if (bus_ack && poll_done) state_q <= qfp_pkg::S_FINISH;
        qfp_pkg::S_EXIT: if (bus_ack) begin
          state_q <= wait_q ? qfp_pkg::S_POLL : qfp_pkg::S_FINISH;
        end
        qfp_pkg::S_FINISH: state_q <= qfp_pkg::S_IDLE;
      endcase
    end
  end

  // session flags close on exit (the efp flag only when wait is set), or on a device reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      qefp_q <= 1'b0;
      efp_q  <= 1'b0;
    end else if (flrst_q) begin
      qefp_q <= 1'b0;
      efp_q  <= 1'b0;
    end else if (state_q == qfp_pkg::S_FINISH) begin
      if (op_q == qfp_pkg::OP_QEFP_START) qefp_q <= 1'b1;
      if (op_q == qfp_pkg::OP_EFP_START)  efp_q  <= 1'b1;
      if (op_q == qfp_pkg::OP_EXIT) begin
        qefp_q <= 1'b0;
        if (wait_q) efp_q <= 1'b0;
      end
    end
  end

  // result flags: cleared by a new accepted command, refused set by a rejected go, the rest set by the sequence
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
      acc_err_q <= 1'b0;
      dev_err_q <= 1'b0;
      sr_q      <= '0;
    end else begin
      if (go && state_q == qfp_pkg::S_IDLE && allowed && !bus_busy && !flrst_q) begin
        done_q    <= 1'b0;
        refused_q <= 1'b0;
        acc_err_q <= 1'b0;
        dev_err_q <= 1'b0;
      end else if (go) begin
        refused_q <= 1'b1;
      end
      if (state_q == qfp_pkg::S_FINISH) done_q <= 1'b1;
      if ((state_q == qfp_pkg::S_CHECK || state_q == qfp_pkg::S_POLL) && bus_ack)
        sr_q <= bus_rd[7:0];
      if (state_q == qfp_pkg::S_CHECK && bus_ack && bus_rd[qfp_pkg::SR_READY])
        acc_err_q <= 1'b1;
      if (state_q == qfp_pkg::S_POLL && bus_ack && bus_rd[qfp_pkg::SR_READY] &&
          (bus_rd[7:0] & qfp_pkg::SR_ERR_MASK) != 8'h00)
        dev_err_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------- pins
  qfp_sync u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (fl_dq_i),
    .dout   (dq_sync)
  );

  qfp_bus_cycle u_bus (
    .clock    (clock),
    .arst_n   (arst_n),
    .req      (bus_req),
    .we       (bus_we),
    .addr     (bus_addr),
    .wdata    (bus_wdata),
    .rdata    (dq_sync),
    .ack      (bus_ack),
    .busy     (bus_busy),
    .rd_q     (bus_rd),
    .fl_addr  (fl_addr),
    .fl_dq_o  (fl_dq_o),
    .fl_dq_oe (fl_dq_oe),
    .fl_ce_n  (fl_ce_n),
    .fl_we_n  (fl_we_n),
    .fl_oe_n  (fl_oe_n)
  );
endmodule // qfp_host

// *** src/qfp_pkg.sv ***
// constants, register map and state types for the factory program host controller
// assumes one 250 MHz clock and a 21-bit word address, 16-bit data flash bus
package qfp_pkg;
  localparam int CLK_MHZ = 250;
  localparam int AW      = 21;
  localparam int DW      = 16;
  localparam int CW      = 8;

  // flash bus timing in ns; least times round up to whole cycles
  localparam int T_SETUP_NS   = 10;
  localparam int T_WR_PULSE_NS = 45;
  localparam int T_RD_ACC_NS  = 70;
  localparam int T_RECOVER_NS = 30;
  localparam int SYNC_CYC     = 2;
  localparam logic [CW-1:0] SETUP_CYC = CW'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] WR_CYC    = CW'((T_WR_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] RD_CYC    = CW'((T_RD_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
  localparam logic [CW-1:0] REC_CYC   = CW'((T_RECOVER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] CNT_ONE   = 8'h01;

  // command codes and data put on the flash bus
  localparam logic [DW-1:0] CODE_DWP     = 16'h0035;
  localparam logic [DW-1:0] CODE_QWP     = 16'h0056;
  localparam logic [DW-1:0] CODE_QEFP    = 16'h0075;
  localparam logic [DW-1:0] CODE_EFP     = 16'h0030;
  localparam logic [DW-1:0] CODE_CONFIRM = 16'h00d0;
  localparam logic [DW-1:0] EXIT_DATA    = 16'hffff;

  // device status word positions
  localparam int SR_READY = 7;
  localparam int SR_BANKW = 0;
  localparam logic [7:0] SR_ERR_MASK = 8'h3a;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_START  = 8'h04;
  localparam logic [7:0] REG_EXIT   = 8'h08;
  localparam logic [7:0] REG_WORD0  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam int         NWORDS     = 4;
  localparam logic [5:0] WORD0_IDX  = 6'h03;

  // ctrl fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO     = 3;
  localparam int CTRL_WAIT   = 4;
  localparam int CTRL_FLRST  = 5;

  // status fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_ACC_ERR = 3;
  localparam int ST_DEV_ERR = 4;
  localparam int ST_QEFP    = 5;
  localparam int ST_EFP     = 6;
  localparam int ST_SR_LSB  = 8;

  typedef enum logic [2:0] {
    OP_READ       = 3'b000,
    OP_DWP        = 3'b001,
    OP_QWP        = 3'b010,
    OP_QEFP_START = 3'b011,
    OP_QEFP_PAGE  = 3'b100,
    OP_EFP_START  = 3'b101,
    OP_EFP_WORD   = 3'b110,
    OP_EXIT       = 3'b111
  } qfp_op_t;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_SETUP   = 3'b001,
    S_CONFIRM = 3'b010,
    S_WORD    = 3'b011,
    S_CHECK   = 3'b100,
    S_POLL    = 3'b101,
    S_EXIT    = 3'b110,
    S_FINISH  = 3'b111
  } qfp_state_t;

  typedef enum logic [1:0] {
    B_IDLE  = 2'b00,
    B_SETUP = 2'b01,
    B_PULSE = 2'b10,
    B_REC   = 2'b11
  } qfp_bus_t;
endpackage

// *** src/qfp_sync.sv ***
// two-flop synchroniser for the flash data pins
// assumes the pins change with no relation to clock
`timescale 1ns/1ps
module qfp_sync (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // pins in, synchronised out
  input  wire logic [qfp_pkg::DW-1:0] din,
  output logic      [qfp_pkg::DW-1:0] dout
);
  logic [qfp_pkg::DW-1:0] meta_q;

  genvar b;
  generate
    for (b = 0; b < qfp_pkg::DW; b++) begin : g_bit
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          meta_q[b] <= 1'b0;
          dout[b]   <= 1'b0;
        end else begin
          meta_q[b] <= din[b];
          dout[b]   <= meta_q[b];
        end
      end
    end
  endgenerate
endmodule // qfp_sync
